/* File: hw/pzs_core.sv */
`timescale 1ns/1ps
`include "pzs_defs.svh"
module pzs_core #(
	parameter int ADDR_W = `PZS_ADDR_W,
	parameter int DATA_W = `PZS_DATA_W,
	parameter int LANES = `PZS_LANES,
	parameter int FIFO_DEPTH = `PZS_FIFO_DEPTH
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic read_not_write_i,
	input wire logic advance_not_load_i,
	input wire logic chip_sel_a_n_i,
	input wire logic chip_sel_b_i,
	input wire logic chip_sel_c_n_i,
	input wire logic clk_hold_n_i,
	input wire logic [LANES-1:0] lane_write_n_i,
	input wire logic output_drive_n_i,
	input wire logic burst_order_sel_i,
	input wire logic [DATA_W-1:0] dq_i,
	output logic [DATA_W-1:0] dq_o,
	output logic dq_oe_o
);
	import pzs_pkg::*;
	localparam int LW = DATA_W / LANES;
	localparam int CW = `PZS_BURST_CNT_W;
	localparam int EW = ADDR_W + DATA_W + LANES;

	initial begin
		if (LANES < 1 || DATA_W % LANES != 0 || ADDR_W < CW) begin
			$error("pzs_core: DATA_W must split evenly into LANES, ADDR_W at least 2");
		end
	end

	typedef struct packed {
		pzs_op_t op1;
		logic [ADDR_W-1:0] addr1;
		logic [LANES-1:0] lanes1;
		pzs_op_t op2;
		logic [ADDR_W-1:0] addr2;
		logic [LANES-1:0] lanes2;
		pzs_op_t bop;
		logic [ADDR_W-1:0] bbase;
		logic [CW-1:0] bcnt;
		logic drive;
		logic [DATA_W-1:0] dout;
	} pzs_core_state_t;

	pzs_core_state_t r, n;

	logic enabled;
	logic selected;
	logic rd_deliver;
	logic wr_deliver;
	logic [DATA_W-1:0] store_rd;
	logic [DATA_W-1:0] merged_rd;
	logic push_ready;
	logic drain_valid;
	logic drain_ready;
	logic [EW-1:0] push_data;
	logic [EW-1:0] drain_data;
	logic [FIFO_DEPTH*EW-1:0] ents;
	logic [FIFO_DEPTH-1:0] ents_vld;

	function automatic logic [ADDR_W-1:0] pzs_burst_addr(
		input logic [ADDR_W-1:0] base,
		input logic [CW-1:0] cnt,
		input logic order
	);
		logic [ADDR_W-1:0] a;
		a = base;
		if (order == `PZS_ORDER_LINEAR) begin
			a[CW-1:0] = base[CW-1:0] + cnt;
		end else begin
			a[CW-1:0] = base[CW-1:0] ^ cnt;
		end
		return a;
	endfunction

	assign enabled = ~clk_hold_n_i;
	assign selected = ~chip_sel_a_n_i & chip_sel_b_i & ~chip_sel_c_n_i;
	assign rd_deliver = enabled && (r.op2 == PZS_OP_READ);
	assign wr_deliver = enabled && (r.op2 == PZS_OP_WRITE);

	// Pending writes still in the FIFO override the array
	always_comb begin
		logic [EW-1:0] e;
		e = '0;
		merged_rd = store_rd;
		for (int j = 0; j < FIFO_DEPTH; j++) begin
			e = ents[j*EW +: EW];
			if (ents_vld[j] && e[EW-1 -: ADDR_W] == r.addr2) begin
				for (int k = 0; k < LANES; k++) begin
					if (e[k]) begin
						merged_rd[k*LW +: LW] = e[LANES + k*LW +: LW];
					end
				end
			end
		end
	end

	always_comb begin
		n = r;
		if (enabled) begin
			// Stage two completes
			n.drive = 1'b0;
			if (r.op2 == PZS_OP_READ) begin
				n.drive = 1'b1;
				n.dout = merged_rd;
			end
			n.op2 = r.op1;
			n.addr2 = r.addr1;
			n.lanes2 = r.lanes1;
			// New stage one
			n.op1 = PZS_OP_NONE;
			if (!advance_not_load_i) begin
				if (selected) begin
					n.op1 = read_not_write_i ? PZS_OP_READ : PZS_OP_WRITE;
					n.addr1 = addr_i;
					n.lanes1 = ~lane_write_n_i;
					n.bop = n.op1;
					n.bbase = addr_i;
					n.bcnt = '0;
				end else begin
					n.bop = PZS_OP_NONE;
				end
			end else if (r.bop != PZS_OP_NONE) begin
				n.bcnt = r.bcnt + 1'b1;
				n.op1 = r.bop;
				n.addr1 = pzs_burst_addr(r.bbase, n.bcnt, burst_order_sel_i);
				n.lanes1 = ~lane_write_n_i;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign dq_o = r.dout;
	assign dq_oe_o = r.drive & ~output_drive_n_i;

	// Write data taken on its delivery edge
	assign push_data = {r.addr2, dq_i, r.lanes2};
	assign drain_ready = ~rd_deliver;

	pzs_fifo #(
		.W(EW),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.in_valid_i(wr_deliver),
		.in_ready_o(push_ready),
		.in_data_i(push_data),
		.out_valid_o(drain_valid),
		.out_ready_i(drain_ready),
		.out_data_o(drain_data),
		.ents_o(ents),
		.ents_vld_o(ents_vld)
	);

	pzs_store #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W),
		.LANES(LANES)
	) u_store (
		.clock_i(clock_i),
		.rd_addr_i(r.addr2),
		.rd_data_o(store_rd),
		.wr_en_i(drain_valid && drain_ready),
		.wr_addr_i(drain_data[EW-1 -: ADDR_W]),
		.wr_data_i(drain_data[LANES +: DATA_W]),
		.wr_lanes_i(drain_data[LANES-1:0])
	);
endmodule

/* File: hw/pzs_defs.svh */
// Contract
// - An operation starts on an enabled edge with advance_not_load low and all three selects on; read_not_write picks read or write and lane_write_n picks the lanes.
// - On an edge with clk_hold_n high every synchronous input is ignored, the pipeline holds and driven read data stays on the bus.
// - Read data appears after the second enabled edge following its load, suspended edges not counted.
// - A new read load is taken on the same edge that delivers the read loaded two enabled edges earlier.
// - A deselect with advance_not_load low starts nothing, yet an already loaded read still delivers on time.
// - An already loaded write still captures its data two enabled edges after its load despite a following deselect.
// - The data outputs are high-impedance from the first edge after power-up.
// - While bursting, read_not_write is ignored and the direction stays as captured at the load.
// - A burst ends as soon as a new load is sampled with advance_not_load low.
`ifndef PZS_DEFS_SVH
`define PZS_DEFS_SVH
`define PZS_ADDR_W 18
`define PZS_DATA_W 18
`define PZS_LANES 2
`define PZS_FIFO_DEPTH 16
`define PZS_BURST_CNT_W 2
`define PZS_ORDER_LINEAR 1'b0
`endif

/* File: hw/pzs_pkg.sv */
package pzs_pkg;
	typedef enum logic [1:0] {
		PZS_OP_NONE,
		PZS_OP_READ,
		PZS_OP_WRITE
	} pzs_op_t;
endpackage

/* File: hw/pzs_fifo.sv */
`timescale 1ns/1ps
`include "pzs_defs.svh"
module pzs_fifo #(
	parameter int W = 8,
	parameter int DEPTH = `PZS_FIFO_DEPTH
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o,
	output logic [DEPTH*W-1:0] ents_o,
	output logic [DEPTH-1:0] ents_vld_o
);
	import pzs_pkg::*;
	localparam int PW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << PW) != DEPTH || W < 1) begin
			$error("pzs_fifo: DEPTH must be a power of two of at least 2");
		end
	end
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] rd;
		logic [PW-1:0] wr;
		logic [PW:0] cnt;
	} pzs_fifo_state_t;
	pzs_fifo_state_t r, n;
	logic push, pop;
	assign out_valid_o = (r.cnt != '0);
	assign in_ready_o = (r.cnt != (PW+1)'(DEPTH)) || out_ready_i;
	assign out_data_o = r.mem[r.rd];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wr] = in_data_i;
			n.wr = r.wr + 1'b1;
		end
		if (pop) begin
			n.rd = r.rd + 1'b1;
		end
		n.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
	// Entries oldest first
	for (genvar j = 0; j < DEPTH; j++) begin : g_ent
		logic [PW-1:0] idx;
		assign idx = r.rd + PW'(j);
		assign ents_o[j*W +: W] = r.mem[idx];
		assign ents_vld_o[j] = (r.cnt > (PW+1)'(j));
	end
endmodule

/* File: hw/pzs_store.sv */
`timescale 1ns/1ps
`include "pzs_defs.svh"
module pzs_store #(
	parameter int ADDR_W = `PZS_ADDR_W,
	parameter int DATA_W = `PZS_DATA_W,
	parameter int LANES = `PZS_LANES
) (
	input wire logic clock_i,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [DATA_W-1:0] rd_data_o,
	input wire logic wr_en_i,
	input wire logic [ADDR_W-1:0] wr_addr_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	input wire logic [LANES-1:0] wr_lanes_i
);
	import pzs_pkg::*;
	localparam int LW = DATA_W / LANES;
	logic [DATA_W-1:0] mem [1<<ADDR_W];
	assign rd_data_o = mem[rd_addr_i];
	// Byte-lane write
	for (genvar k = 0; k < LANES; k++) begin : g_lane
		always_ff @(posedge clock_i) begin
			if (wr_en_i && wr_lanes_i[k]) begin
				mem[wr_addr_i][k*LW +: LW] <= wr_data_i[k*LW +: LW];
			end
		end
	end
endmodule

/* File: tb/pzs_checker.sv */
`timescale 1ns/1ps
module pzs_checker #(parameter int DATA_W = 18) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic read_not_write_i,
	input wire logic advance_not_load_i,
	input wire logic chip_sel_a_n_i,
	input wire logic chip_sel_b_i,
	input wire logic chip_sel_c_n_i,
	input wire logic clk_hold_n_i,
	input wire logic output_drive_n_i,
	input wire logic [DATA_W-1:0] dq_o,
	input wire logic dq_oe_o
);
	logic act_r, dir_r;
	logic [1:0] rd_p;
	wire hold = clk_hold_n_i;
	wire odn = output_drive_n_i;
	wire ld = !advance_not_load_i;
	wire go = ld ? !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i : act_r;
	wire rd = ld ? read_not_write_i : dir_r;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			{act_r, dir_r, rd_p} <= '0;
		end else if (!hold) begin
			act_r <= go;
			dir_r <= rd;
			rd_p <= {rd_p[0], go && rd};
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	a_stall_data: assert property (hold |=> $stable(dq_o))
		else $error("stall moved data");
	a_stall_drive: assert property (hold ##1 $stable(odn) |-> $stable(dq_oe_o))
		else $error("stall moved drive");
	a_rd_deliver: assert property (!hold && rd_p[1] |=> dq_oe_o || odn)
		else $error("read not driven");
	a_b2b_read: assert property (!hold && rd_p[1] && rd_p[0] ##1 !hold |=> dq_oe_o || odn)
		else $error("second read lost");
	a_desel_read: assert property (!hold && rd_p[1] && !go && ld |=> dq_oe_o || odn)
		else $error("read lost on deselect");
	a_no_drive: assert property (!hold && !rd_p[1] |=> !dq_oe_o)
		else $error("bus driven without read");
	a_oe_gate: assert property (odn |-> !dq_oe_o)
		else $error("drive while disabled");
	a_power_float: assert property (disable iff (1'b0) rst_i |=> !dq_oe_o)
		else $error("drive in reset");
endmodule
bind pzs_core pzs_checker #(.DATA_W(DATA_W)) u_chk (.*);

/* File: tb/pzs_ctrl_model.sv */
`timescale 1ns/1ps
module pzs_ctrl_model (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic adv_i,
	input wire logic sel_i,
	input wire logic rnw_i,
	input wire logic hold_n_i,
	input wire logic [17:0] wdat_i,
	output logic [17:0] dq_o
);
	logic act_r, dir_r;
	logic [1:0] wv_r;
	logic [17:0] d0_r, d1_r;
	wire go = adv_i ? act_r : sel_i;
	wire wr = go && !(adv_i ? dir_r : rnw_i);
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			{act_r, dir_r, wv_r} <= '0;
		end else if (!hold_n_i) begin
			act_r <= go;
			dir_r <= adv_i ? dir_r : rnw_i;
			wv_r <= {wv_r[0], wr};
			{d1_r, d0_r} <= {d0_r, wdat_i};
		end
	end
	// Bus toggles when no write data is due
	initial dq_o = '0;
	always @(negedge clock_i) dq_o <= wv_r[1] ? d1_r : ~dq_o;
endmodule

/* File: tb/tb_pzs_core.sv */
`timescale 1ns/1ps
module tb_pzs_core;
	import pzs_pkg::*;
	typedef struct packed {pzs_op_t k; logic [2:0] a; logic [1:0] ln; logic [17:0] d;} pzs_tb_op_t;
	logic clock_i = 1'h0, rst_i = 1'h1, rnw = 1'h0, adv = 1'h0, hn = 1'h0, odn = 1'h0;
	logic bos = 1'h0, dq_oe_o, bact = 1'h0, bdir = 1'h0;
	logic [2:0] bb = '0;
	logic [1:0] bc = '0;
	logic [2:0] cs = 3'h2;
	logic [1:0] ln = '0;
	logic [17:0] addr = '0, wd = '0, dqi, dq_o, mem [8];
	pzs_tb_op_t p0 = '0, p1 = '0;
	int error_cnt = 0, n_compared = 0, i, k;
	always #20 clock_i = ~clock_i;
	pzs_core u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .read_not_write_i(rnw),
		.advance_not_load_i(adv), .chip_sel_a_n_i(cs[2]), .chip_sel_b_i(cs[1]),
		.chip_sel_c_n_i(cs[0]), .clk_hold_n_i(hn), .lane_write_n_i(ln), .output_drive_n_i(odn),
		.burst_order_sel_i(bos), .dq_i(dqi), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
	pzs_ctrl_model u_ctl (.clock_i(clock_i), .rst_i(rst_i), .adv_i(adv), .sel_i(cs == 3'h2),
		.rnw_i(rnw), .hold_n_i(hn), .wdat_i(wd), .dq_o(dqi));
	task automatic chk(input string n, input logic [17:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input logic h, v, r, o, input logic [2:0] c, a, input logic [1:0] l);
		pzs_tb_op_t n;
		@(negedge clock_i);
		{hn, adv, rnw, odn, cs, ln} = {h, v, r, o, c, l};
		addr = {15'h0, a};
		wd = 18'($urandom);
		bos = 1'($urandom);
		@(posedge clock_i);
		#1;
		if (!h) begin
			// Burst tracking: load restarts, deselect stops, advance steps the count
			if (!v) begin
				bact = (c == 3'h2);
				bdir = r;
				bb = a;
				bc = 2'h0;
			end else if (bact) begin
				bc = bc + 2'h1;
			end
			n = '{!bact ? PZS_OP_NONE : bdir ? PZS_OP_READ : PZS_OP_WRITE,
				bos ? bb ^ {1'b0, bc} : {bb[2], bb[1:0] + bc}, l, wd};
			if (p1.k == PZS_OP_WRITE) begin
				for (int j = 0; j < 2; j++) if (!p1.ln[j]) mem[p1.a][9*j+:9] = p1.d[9*j+:9];
			end
			chk("drive", dq_oe_o, p1.k == PZS_OP_READ && !o);
			if (p1.k == PZS_OP_READ && !o) chk("data", dq_o, mem[p1.a]);
			p1 = p0;
			p0 = n;
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		final_report;
	end
	initial begin
		i = $urandom(33517);
		repeat (2) @(negedge clock_i);
		chk("reset drive", dq_oe_o, 1'h0);
		rst_i = 1'h0;
		for (i = 0; i < 8; i++) cyc(0, 0, 0, 0, 3'h2, 3'(i), 2'h0);
		$display("test fill done");
		for (i = 0; i < 8; i++) cyc(i == 1 || i == 3 || i == 4, 0, 1, 0, 3'h2, 3'(i), 2'h0);
		$display("test stall done");
		for (k = 0; k < 2; k++) begin
			for (i = 0; i < 10; i++) begin
				cyc(0, 0, k[0], 0, (i == 2 || i == 4 || i == 7) ? 3'h2 : 3'h2 ^ (3'h4 >> i % 3),
					3'(i), 2'(i));
			end
		end
		$display("test deselect done");
		for (i = 0; i < 400; i++) begin
			cyc($urandom % 4 == 0, 0, 1'($urandom), $urandom % 8 == 0,
				$urandom % 5 ? 3'h2 : 3'($urandom), 3'($urandom), 2'($urandom));
		end
		$display("test random done");
		for (i = 0; i < 200; i++) begin
			cyc($urandom % 4 == 0, $urandom % 3 != 0, 1'($urandom), $urandom % 8 == 0,
				$urandom % 4 ? 3'h2 : 3'($urandom), 3'($urandom), 2'($urandom));
		end
		$display("test burst done");
		final_report;
	end
endmodule
